// file: core/kdc_core.sv
// Password compare-and-copy, key selector and nonce logic behind an AHB-Lite slave
// Notes on behaviour
// - Copy happens only when the target slot's read key field is zero.
// - Copy is possible only with compare mode 0x01.
// - Digest message is password slot then random nonce from the scratch register.
// - On digest match under copy conditions, target slot goes to the scratch register.
// - After copy: origin one, store and compare-only flags zero, valid one.
// - Compare command checks response against computed digest, reports true or false.
// - Selectors 0x8000 and up are hidden keys, rejected only by compare and encrypted read or write.
// - Below 0x8000 slot is low four bits; full selector enters the message.
// - Generator yields 32 bytes mixed with host input number into the nonce.
// - Standalone random command never alters the scratch register.
// - Before config lock the generator repeats ff ff 00 00, first byte first.
// - Encrypted read or write needs a digest key built from a random nonce.
// - Output mixes entropy with an internal seed that is never readable.
// - Seed refreshed once per power-up or wake; sleep or power loss invalidates it.
// - Mode bit of nonce and random skips the seed refresh; host uses sparingly.
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`include "kdc_map.svh"
module kdc_core (
    // Clock, reset, enable
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic hready_i,
    input wire logic [31:0] hwdata_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Pins from outside the clock domain
    input wire logic sleep_i,
    input wire logic [31:0] entropy_i,
    // Digest engine
    output logic sha_start_o,
    output kdc_pkg::kdc_sha_msg_s sha_msg_o,
    input wire logic sha_done_i,
    input wire logic [255:0] sha_digest_i,
    // Seed store and interrupt
    output logic seed_store_o,
    output logic irq_o
);
    import kdc_pkg::*;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction
    function automatic logic hit8(input logic [11:0] a, input logic [11:0] off);
        return a[11:5] == off[11:5];
    endfunction

    // Not a hash: cheap whitening, the digest engine does the real work
    function automatic logic [31:0] mix(input logic [31:0] s, input logic [31:0] e,
                                        input logic [2:0] k);
        return {s[26:0], s[31:27]} ^ e ^ {8{1'b0, k}};
    endfunction

    logic [31:0] ent_meta_ff, ent_ff;
    logic slp_meta_ff, slp_ff;
    logic wr_pend_ff;
    logic [11:0] wr_addr_ff;
    logic [31:0] hrdata_ff, rd_val;
    logic [1:0] ctrl_ff;
    logic [2:0] irq_stat_ff, irq_mask_ff;
    logic irq_ff;
    logic [31:0] innum_ff [8];
    logic [31:0] resp_ff [8];
    logic [31:0] rand_ff [8];
    logic [31:0] scratch_ff [8];
    logic [31:0] slot_mem [16][8];
    logic [3:0] rk_mem [16];
    logic sc_valid_ff, sc_origin_ff, sc_store_ff, sc_check_ff;
    logic dpk_valid_ff, dpk_rand_ff;
    logic [31:0] seed_ff;
    logic seed_valid_ff, seed_store_ff;
    logic result_ff;
    kdc_state_e state_ff;
    logic [2:0] cnt_ff;
    logic [7:0] op_ff, mode_ff;
    logic [15:0] ks_ff;
    logic ev_done_ff, ev_err_ff, ev_miss_ff;
    logic sha_start_ff;
    kdc_sha_msg_s sha_msg_ff;
    logic [255:0] scratch_vec, resp_vec;
    logic wr_en, cmd_wr, hidden, match, copy_ok, locked;
    logic [3:0] pwd_slot, tgt_slot;
    logic [31:0] gen_word;

    // Pin inputs pass two flops before use
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ent_meta_ff <= 32'h0;
            ent_ff <= 32'h0;
            slp_meta_ff <= 1'b0;
            slp_ff <= 1'b0;
        end else if (ce_i) begin
            ent_meta_ff <= entropy_i;
            ent_ff <= ent_meta_ff;
            slp_meta_ff <= sleep_i;
            slp_ff <= slp_meta_ff;
        end
    end

    // Bus slave: zero wait states, always OKAY, writes land in the data phase
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= 12'h0;
            hrdata_ff <= 32'h0;
        end else if (ce_i) begin
            wr_pend_ff <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
            wr_addr_ff <= haddr_i[11:0];
            hrdata_ff <= (hsel_i & htrans_i[1] & hready_i & ~hwrite_i) ? rd_val : 32'h0;
        end
    end
    assign hrdata_o = hrdata_ff;
    assign wr_en = wr_pend_ff;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (ce_i) begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // Secrets, seed and response read back as zero
    always_comb begin
        rd_val = 32'h0;
        if (hit(haddr_i[11:0], `KDC_OFF_CTRL)) begin
            rd_val = {30'h0, ctrl_ff};
        end else if (hit(haddr_i[11:0], `KDC_OFF_STATUS)) begin
            rd_val = {25'h0, seed_valid_ff, sc_check_ff, sc_store_ff, sc_origin_ff,
                      sc_valid_ff, result_ff, state_ff != ST_IDLE};
        end else if (hit(haddr_i[11:0], `KDC_OFF_IRQ_STAT)) begin
            rd_val = {29'h0, irq_stat_ff};
        end else if (hit(haddr_i[11:0], `KDC_OFF_IRQ_MASK)) begin
            rd_val = {29'h0, irq_mask_ff};
        end else if (hit8(haddr_i[11:0], `KDC_OFF_RAND)) begin
            rd_val = rand_ff[haddr_i[4:2]];
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ctrl_ff <= `KDC_CTRL_RST;
            irq_mask_ff <= `KDC_IRQ_RST;
        end else if (ce_i && wr_en) begin
            if (hit(wr_addr_ff, `KDC_OFF_CTRL)) begin
                ctrl_ff <= hwdata_i[1:0];
            end
            if (hit(wr_addr_ff, `KDC_OFF_IRQ_MASK)) begin
                irq_mask_ff <= hwdata_i[2:0];
            end
        end
    end

    // Host-loaded words and slot contents; no reset needed for data storage
    always_ff @(posedge core_clk_i) begin
        if (ce_i && wr_en) begin
            if (hit8(wr_addr_ff, `KDC_OFF_INNUM)) begin
                innum_ff[wr_addr_ff[4:2]] <= hwdata_i;
            end
            if (hit8(wr_addr_ff, `KDC_OFF_RESP)) begin
                resp_ff[wr_addr_ff[4:2]] <= hwdata_i;
            end
            if (wr_addr_ff[11:9] == `KDC_SLOT_BASE_SEL) begin
                slot_mem[wr_addr_ff[8:5]][wr_addr_ff[4:2]] <= hwdata_i;
            end
            if (hit(wr_addr_ff, `KDC_OFF_READ_KEY)) begin
                rk_mem[hwdata_i[3:0]] <= hwdata_i[7:4];
            end
        end
    end

    // Sticky events, write one to clear, a new event beats the clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_stat_ff <= `KDC_IRQ_RST;
            irq_ff <= 1'b0;
        end else if (ce_i) begin
            irq_stat_ff <= (irq_stat_ff & ~((wr_en && hit(wr_addr_ff, `KDC_OFF_IRQ_STAT))
                           ? hwdata_i[2:0] : 3'h0)) | {ev_miss_ff, ev_err_ff, ev_done_ff};
            irq_ff <= |(irq_stat_ff & irq_mask_ff);
        end
    end
    assign irq_o = irq_ff;

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            scratch_vec[32*i +: 32] = scratch_ff[i];
            resp_vec[32*i +: 32] = resp_ff[i];
        end
    end

    assign locked = ctrl_ff[`KDC_CTRL_LOCK_BIT];
    assign cmd_wr = wr_en && hit(wr_addr_ff, `KDC_OFF_CMD) && state_ff == ST_IDLE;
    assign hidden = ks_ff >= `KDC_HIDDEN_MIN;
    assign pwd_slot = ks_ff[3:0];
    assign tgt_slot = pwd_slot + {3'h0, ctrl_ff[`KDC_CTRL_SECOND_BIT]};
    assign match = sha_digest_i == resp_vec;
    assign copy_ok = mode_ff == `KDC_COPY_MODE && rk_mem[tgt_slot] == `KDC_RK_COPY
                     && sc_valid_ff && !sc_origin_ff;
    assign gen_word = locked ? mix(seed_ff, ent_ff, cnt_ff) : `KDC_TEST_PATTERN;

    // Command sequencer, scratch register and seed
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 3'h0;
            op_ff <= 8'h0;
            mode_ff <= 8'h0;
            ks_ff <= 16'h0;
            sc_valid_ff <= 1'b0;
            sc_origin_ff <= 1'b0;
            sc_store_ff <= 1'b0;
            sc_check_ff <= 1'b0;
            dpk_valid_ff <= 1'b0;
            dpk_rand_ff <= 1'b0;
            seed_ff <= 32'h0;
            seed_valid_ff <= 1'b0;
            seed_store_ff <= 1'b0;
            result_ff <= 1'b0;
            ev_done_ff <= 1'b0;
            ev_err_ff <= 1'b0;
            ev_miss_ff <= 1'b0;
            sha_start_ff <= 1'b0;
            sha_msg_ff <= '0;
            for (int i = 0; i < 8; i++) begin
                scratch_ff[i] <= 32'h0;
                rand_ff[i] <= 32'h0;
            end
        end else if (ce_i) begin
            ev_done_ff <= 1'b0;
            ev_err_ff <= 1'b0;
            ev_miss_ff <= 1'b0;
            sha_start_ff <= 1'b0;
            seed_store_ff <= 1'b0;
            unique case (state_ff)
                ST_IDLE: begin
                    if (cmd_wr) begin
                        op_ff <= hwdata_i[7:0];
                        mode_ff <= hwdata_i[15:8];
                        ks_ff <= hwdata_i[31:16];
                        state_ff <= ST_DISP;
                    end
                end
                ST_DISP: begin
                    state_ff <= ST_FIN;
                    result_ff <= 1'b0;
                    case (op_ff)
                        OP_NONCE, OP_RANDOM: begin
                            cnt_ff <= 3'h0;
                            state_ff <= ST_GEN;
                            if (!seed_valid_ff && !mode_ff[`KDC_MODE_SKIP_BIT]) begin
                                seed_ff <= mix(seed_ff, ent_ff, 3'h0);
                                seed_valid_ff <= 1'b1;
                                seed_store_ff <= 1'b1;
                            end
                        end
                        OP_GENDIG: begin
                            dpk_valid_ff <= sc_valid_ff;
                            dpk_rand_ff <= sc_valid_ff && !sc_origin_ff;
                            result_ff <= 1'b1;
                        end
                        OP_CMAC: begin
                            if (hidden) begin
                                ev_err_ff <= 1'b1;
                            end else begin
                                for (int i = 0; i < 8; i++) begin
                                    sha_msg_ff.first[32*i +: 32] <= slot_mem[pwd_slot][i];
                                end
                                sha_msg_ff.second <= scratch_vec;
                                sha_msg_ff.key_sel <= ks_ff;
                                sha_start_ff <= 1'b1;
                                state_ff <= ST_SHA;
                            end
                        end
                        OP_ENCRW: begin
                            if (hidden || !dpk_valid_ff || !dpk_rand_ff) begin
                                ev_err_ff <= 1'b1;
                            end else begin
                                result_ff <= 1'b1;
                            end
                        end
                        default: ev_err_ff <= 1'b1;
                    endcase
                end
                ST_GEN: begin
                    if (op_ff == OP_NONCE) begin
                        scratch_ff[cnt_ff] <= gen_word ^ innum_ff[cnt_ff];
                    end else begin
                        rand_ff[cnt_ff] <= gen_word;
                    end
                    cnt_ff <= cnt_ff + 3'h1;
                    if (cnt_ff == `KDC_LAST_WORD) begin
                        state_ff <= ST_FIN;
                        result_ff <= 1'b1;
                        if (op_ff == OP_NONCE) begin
                            sc_valid_ff <= 1'b1;
                            sc_origin_ff <= 1'b0;
                            sc_store_ff <= 1'b0;
                            sc_check_ff <= 1'b0;
                            dpk_valid_ff <= 1'b0;
                        end
                    end
                end
                ST_SHA: begin
                    if (sha_done_i) begin
                        state_ff <= ST_FIN;
                        result_ff <= match;
                        ev_miss_ff <= !match;
                        if (match && copy_ok) begin
                            for (int i = 0; i < 8; i++) begin
                                scratch_ff[i] <= slot_mem[tgt_slot][i];
                            end
                            sc_origin_ff <= 1'b1;
                            sc_store_ff <= 1'b0;
                            sc_check_ff <= 1'b0;
                            sc_valid_ff <= 1'b1;
                        end
                    end
                end
                ST_FIN: begin
                    ev_done_ff <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
            if (slp_ff) begin
                seed_valid_ff <= 1'b0;
            end
        end
    end
    assign sha_start_o = sha_start_ff;
    assign sha_msg_o = sha_msg_ff;
    assign seed_store_o = seed_store_ff;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_copy_flags;
        ce_i && state_ff == ST_SHA && sha_done_i && match && copy_ok
        |=> sc_origin_ff && !sc_store_ff && !sc_check_ff && sc_valid_ff && result_ff;
    endproperty
    a_copy_flags: assert property (p_copy_flags) else $error("copy flags wrong");
    property p_copy_data;
        ce_i && state_ff == ST_SHA && sha_done_i && match && copy_ok
        |=> scratch_ff[0] == $past(slot_mem[tgt_slot][0]);
    endproperty
    a_copy_data: assert property (p_copy_data) else $error("slot not copied");
    property p_miss;
        ce_i && state_ff == ST_SHA && sha_done_i && !match
        |=> $stable(scratch_vec) && !result_ff ##1 irq_stat_ff[`KDC_IRQ_MISS_BIT];
    endproperty
    a_miss: assert property (p_miss) else $error("mismatch altered scratch");
    property p_rk_block;
        ce_i && state_ff == ST_SHA && sha_done_i && rk_mem[tgt_slot] != `KDC_RK_COPY
        |=> $stable(scratch_vec);
    endproperty
    a_rk_block: assert property (p_rk_block) else $error("copy with read key set");
    property p_mode_block;
        ce_i && state_ff == ST_SHA && sha_done_i && mode_ff != `KDC_COPY_MODE
        |=> $stable(scratch_vec);
    endproperty
    a_mode_block: assert property (p_mode_block) else $error("copy in wrong mode");
    property p_hidden;
        ce_i && state_ff == ST_DISP && hidden && op_ff != OP_GENDIG && op_ff != OP_NONCE
        && op_ff != OP_RANDOM |=> ev_err_ff && state_ff == ST_FIN;
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden key accepted");
    property p_random_keeps;
        ce_i && state_ff == ST_GEN && op_ff == OP_RANDOM |=> $stable(scratch_vec);
    endproperty
    a_random_keeps: assert property (p_random_keeps) else $error("random hit scratch");
    property p_pattern;
        ce_i && state_ff == ST_GEN && op_ff == OP_RANDOM && !locked && cnt_ff == 3'h0
        |=> rand_ff[0] == `KDC_TEST_PATTERN;
    endproperty
    a_pattern: assert property (p_pattern) else $error("test pattern wrong");
    property p_enc;
        ce_i && state_ff == ST_DISP && op_ff == OP_ENCRW && !dpk_rand_ff |=> ev_err_ff;
    endproperty
    a_enc: assert property (p_enc) else $error("encrypted access without nonce");
    property p_sleep;
        ce_i && slp_ff |=> !seed_valid_ff;
    endproperty
    a_sleep: assert property (p_sleep) else $error("seed kept over sleep");
endmodule // kdc_core

// file: core/kdc_map.svh
// Register offsets, field positions, reset values and fixed codes of the key logic
`ifndef KDC_MAP_SVH
`define KDC_MAP_SVH
`define KDC_OFF_CTRL 12'h000
`define KDC_OFF_CMD 12'h004
`define KDC_OFF_STATUS 12'h008
`define KDC_OFF_IRQ_STAT 12'h00c
`define KDC_OFF_IRQ_MASK 12'h010
`define KDC_OFF_READ_KEY 12'h014
`define KDC_OFF_INNUM 12'h020
`define KDC_OFF_RAND 12'h040
`define KDC_OFF_RESP 12'h060
`define KDC_SLOT_BASE_SEL 3'h1
`define KDC_CTRL_LOCK_BIT 0
`define KDC_CTRL_SECOND_BIT 1
`define KDC_CTRL_RST 2'h0
`define KDC_IRQ_DONE_BIT 0
`define KDC_IRQ_ERR_BIT 1
`define KDC_IRQ_MISS_BIT 2
`define KDC_IRQ_RST 3'h0
`define KDC_MODE_SKIP_BIT 0
`define KDC_HIDDEN_MIN 16'h8000
`define KDC_COPY_MODE 8'h01
`define KDC_RK_COPY 4'h0
`define KDC_TEST_PATTERN 32'h0000ffff
`define KDC_LAST_WORD 3'h7
`endif

// file: core/kdc_pkg.sv
// Types shared by the key logic
package kdc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DISP = 3'b001,
        ST_GEN = 3'b010,
        ST_SHA = 3'b011,
        ST_FIN = 3'b100
    } kdc_state_e;
    typedef enum logic [7:0] {
        OP_NONCE = 8'h01,
        OP_RANDOM = 8'h02,
        OP_GENDIG = 8'h03,
        OP_CMAC = 8'h04,
        OP_ENCRW = 8'h05
    } kdc_op_e;
    typedef struct packed {
        logic [255:0] first;
        logic [255:0] second;
        logic [15:0] key_sel;
    } kdc_sha_msg_s;
endpackage

// file: verification/kdc_sha_model.sv
// Digest engine stand-in that answers start pulses after a set latency
module kdc_sha_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Request side
    input wire logic start_i,
    input wire kdc_pkg::kdc_sha_msg_s msg_i,
    input wire logic [3:0] lat_i,
    // Answer side
    output logic done_o,
    output logic [255:0] digest_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import kdc_pkg::*;
    logic [3:0] wait_ff;
    logic pend_ff;
    logic [255:0] res_ff;
    logic [31:0] ks;
    always @(posedge core_clk_i) begin
        ks = {16'h0, msg_i.key_sel};
        done_o <= 1'b0;
        // Toggles outside the done cycle so a stale digest never matches
        digest_o <= ~digest_o;
        if (reset_i) begin
            pend_ff <= 1'b0;
            digest_o <= '0;
        end else if (start_i) begin
            pend_ff <= 1'b1;
            wait_ff <= lat_i;
            for (int i = 0; i < 8; i++) begin
                res_ff[32*i+:32] <= msg_i.first[32*i+:32] ^ msg_i.second[32*i+:32] ^ ks;
            end
        end else if (pend_ff && wait_ff == 4'h0) begin
            pend_ff <= 1'b0;
            done_o <= 1'b1;
            digest_o <= res_ff;
        end else if (pend_ff) begin
            wait_ff <= wait_ff - 4'h1;
        end
    end
endmodule // kdc_sha_model

// file: verification/tb_kdc_core.sv
// Bus-driven testbench of the key logic
`include "kdc_map.svh"
module tb_kdc_core;
    timeunit 1ns;
    timeprecision 1ps;
    import kdc_pkg::*;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic sleep = 1'b0;
    logic ce = 1'b1;
    logic [31:0] entropy = 32'h1234abcd;
    logic [3:0] lat = 4'h4;
    logic [31:0] hrdata;
    logic hreadyout, hresp, sha_start, sha_done, seed_store, irq;
    kdc_sha_msg_s sha_msg;
    logic [255:0] sha_digest, pw, sec, innum, nonce;
    logic [31:0] s;
    int errors = 0;
    int total_checks = 0;
    int seeds = 0;
    int n;
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        entropy <= {entropy[30:0], entropy[31] ^ entropy[21]};
        if (seed_store === 1'b1) seeds <= seeds + 1;
    end
    kdc_core u_dut (.core_clk_i(core_clk), .reset_i(reset), .ce_i(ce), .hsel_i(hsel),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
        .hready_i(hreadyout), .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hreadyout),
        .hresp_o(hresp), .sleep_i(sleep), .entropy_i(entropy), .sha_start_o(sha_start),
        .sha_msg_o(sha_msg), .sha_done_i(sha_done), .sha_digest_i(sha_digest),
        .seed_store_o(seed_store), .irq_o(irq));
    kdc_sha_model u_sha (.core_clk_i(core_clk), .reset_i(reset), .start_i(sha_start),
        .msg_i(sha_msg), .lat_i(lat), .done_o(sha_done), .digest_o(sha_digest));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_blk(input logic [255:0] got, input logic [255:0] exp);
        for (int i = 0; i < 8; i++) chk(got[32*i+:32], exp[32*i+:32]);
    endtask
    // Address phase held until hready, then data phase held until hready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                        output logic [31:0] rdat);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'b1, a, d, x);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0, d);
    endtask
    task automatic wblk(input logic [11:0] a, input logic [255:0] v);
        for (int i = 0; i < 8; i++) wr(a + 12'(4 * i), v[32*i+:32]);
    endtask
    // Polls busy under a bound so a stuck engine shows as a mismatch
    task automatic cmd(input logic [7:0] op, input logic [7:0] mode, input logic [15:0] sel);
        wr(`KDC_OFF_CMD, {sel, mode, op});
        for (int i = 0; i < 60; i++) begin
            rd(`KDC_OFF_STATUS, s);
            if (s[0] === 1'b0) break;
        end
        chk({31'h0, s[0]}, 32'h0);
    endtask
    function automatic logic [255:0] dig(input logic [255:0] f, input logic [255:0] x,
                                         input logic [15:0] k);
        for (int i = 0; i < 8; i++) dig[32*i+:32] = f[32*i+:32] ^ x[32*i+:32] ^ {16'h0, k};
    endfunction
    task automatic do_nonce(input logic [7:0] mode);
        wblk(`KDC_OFF_INNUM, innum);
        cmd(OP_NONCE, mode, 16'h0);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 8; i++) begin
            pw[32*i+:32] = 32'h10000000 + 32'(i);
            sec[32*i+:32] = 32'h30000000 + 32'(i);
            innum[32*i+:32] = 32'h5a5a0000 + 32'(i);
        end
        nonce = innum ^ {8{`KDC_TEST_PATTERN}};
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd(`KDC_OFF_STATUS, s);
        chk(s, 32'h0);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s, 32'h0);
        rd(`KDC_OFF_IRQ_MASK, s);
        chk(s, 32'h0);
        rd(12'h100, s);
        chk(s, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        $display("test reset_values done");
        wr(`KDC_OFF_IRQ_MASK, 32'h7);
        cmd(OP_RANDOM, 8'h00, 16'h0);
        for (int i = 0; i < 8; i++) begin
            rd(`KDC_OFF_RAND + 12'(4 * i), s);
            chk(s, `KDC_TEST_PATTERN);
        end
        rd(`KDC_OFF_STATUS, s);
        chk(s & 32'h44, 32'h40);
        chk({31'h0, irq}, 32'h1);
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        repeat (3) @(posedge core_clk);
        chk({31'h0, irq}, 32'h0);
        cmd(OP_RANDOM, 8'h00, 16'h0);
        chk(32'(seeds), 32'h1);
        $display("test random_pattern done");
        wblk(12'h240, pw);
        wblk(12'h260, sec);
        wr(`KDC_OFF_READ_KEY, 32'h03);
        wr(`KDC_OFF_CTRL, 32'h2);
        do_nonce(8'h00);
        rd(`KDC_OFF_STATUS, s);
        chk(s & 32'h0c, 32'h04);
        wblk(`KDC_OFF_RESP, dig(pw, nonce, 16'h2));
        cmd(OP_CMAC, `KDC_COPY_MODE, 16'h2);
        chk_blk(sha_msg.first, pw);
        chk_blk(sha_msg.second, nonce);
        rd(`KDC_OFF_STATUS, s);
        chk(s & 32'h3e, 32'h0e);
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        wblk(`KDC_OFF_RESP, ~dig(pw, sec, 16'h2));
        cmd(OP_CMAC, 8'h00, 16'h2);
        chk_blk(sha_msg.second, sec);
        rd(`KDC_OFF_STATUS, s);
        chk(s & 32'h02, 32'h0);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s & 32'h4, 32'h4);
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        cmd(OP_GENDIG, 8'h00, 16'h2);
        cmd(OP_ENCRW, 8'h00, 16'h2);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s & 32'h2, 32'h2);
        $display("test copy done");
        lat <= 4'h1;
        for (int k = 0; k < 3; k++) begin
            do_nonce(8'h00);
            wr(`KDC_OFF_READ_KEY, k == 0 ? 32'h53 : 32'h03);
            wblk(`KDC_OFF_RESP, k == 2 ? ~dig(pw, nonce, 16'h2) : dig(pw, nonce, 16'h2));
            cmd(OP_CMAC, k == 1 ? 8'h00 : `KDC_COPY_MODE, 16'h2);
            rd(`KDC_OFF_STATUS, s);
            chk(s & 32'h0a, k == 2 ? 32'h0 : 32'h2);
        end
        $display("test no_copy done");
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        do_nonce(8'h00);
        cmd(OP_CMAC, 8'h00, 16'h8000);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s & 32'h2, 32'h2);
        cmd(OP_CMAC, 8'h00, 16'h0032);
        chk({16'h0, sha_msg.key_sel}, 32'h32);
        chk_blk(sha_msg.first, pw);
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        do_nonce(8'h00);
        cmd(OP_GENDIG, 8'h00, 16'h8000);
        cmd(OP_ENCRW, 8'h00, 16'h2);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s & 32'h2, 32'h0);
        $display("test selectors done");
        sleep <= 1'b1;
        repeat (4) @(posedge core_clk);
        sleep <= 1'b0;
        repeat (4) @(posedge core_clk);
        rd(`KDC_OFF_STATUS, s);
        chk(s & 32'h40, 32'h0);
        n = seeds;
        cmd(OP_RANDOM, 8'h01, 16'h0);
        chk(32'(seeds), 32'(n));
        do_nonce(8'h00);
        chk(32'(seeds), 32'(n + 1));
        $display("test seed done");
        wr(`KDC_OFF_CTRL, 32'h1);
        cmd(OP_RANDOM, 8'h00, 16'h0);
        rd(`KDC_OFF_RAND, s);
        chk({31'h0, s === `KDC_TEST_PATTERN}, 32'h0);
        wr(`KDC_OFF_IRQ_STAT, 32'h7);
        cmd(8'h09, 8'h00, 16'h0);
        rd(`KDC_OFF_IRQ_STAT, s);
        chk(s & 32'h2, 32'h2);
        // Frozen block must drop a write issued while enable is low
        ce <= 1'b0;
        wr(`KDC_OFF_IRQ_MASK, 32'h0);
        ce <= 1'b1;
        rd(`KDC_OFF_IRQ_MASK, s);
        chk(s, 32'h7);
        $display("test locked done");
        give_verdict();
    end
endmodule // tb_kdc_core
